//--- src/smon_params.svh
// Constants of the supply monitor register block: command codes, field positions,
// reset values, clamps and serial timing. Included by the receiver, transmitter and register block files.
`ifndef SMON_PARAMS_SVH
`define SMON_PARAMS_SVH

// Threshold write and read command codes.
`define SMON_CMD_WR_LOW_REC   8'h47
`define SMON_CMD_RD_LOW_REC   8'h07
`define SMON_CMD_WR_HIGH_REC  8'h48
`define SMON_CMD_RD_HIGH_REC  8'h08
`define SMON_CMD_WR_SHUTDOWN  8'h49
`define SMON_CMD_RD_SHUTDOWN  8'h09

// Measurement and status read command codes.
`define SMON_CMD_RD_HEATSINK  8'h0A
`define SMON_CMD_RD_BOARD     8'h0B
`define SMON_CMD_RD_SUPPLY    8'h10
`define SMON_CMD_RD_SPEED     8'h11
`define SMON_CMD_RD_LOAD      8'h12
`define SMON_CMD_RD_PERIOD    8'h14
`define SMON_CMD_RD_STATUS    8'h30

// Threshold indices, reset value and maximum; heatsink temperature clamp range.
`define SMON_IDX_LOW_REC      0
`define SMON_IDX_HIGH_REC     1
`define SMON_IDX_SHUTDOWN     2
`define SMON_LEVEL_RESET      12'h000
`define SMON_LEVEL_MAX        14'h0FFF
`define SMON_HEAT_MIN         12'h00A
`define SMON_HEAT_MAX         12'h050

// Data byte layout and status word bits.
`define SMON_DATA_FLAG_BIT    7
`define SMON_HI_LSB           7
`define SMON_STATUS_UV_BIT    0
`define SMON_STATUS_OV_BIT    1

// Serial timing.
`define SMON_CLK_HZ           100000000
`define SMON_BAUD             115200
`define SMON_CLKS_PER_BIT     (`SMON_CLK_HZ / `SMON_BAUD)

`endif

//--- src/smon_pkg.sv
// Types shared by the supply monitor register block.
// Assumes the constants header is available on the include path.
package smon_pkg;

    typedef logic [11:0] smon_level_t;
    typedef logic [13:0] smon_word_t;

    typedef enum logic [2:0] {
        SMON_IDLE,
        SMON_WR_HI,
        SMON_WR_LO,
        SMON_RD_HI,
        SMON_RD_LO
    } smon_cmd_e;

    typedef enum logic [1:0] {
        SMON_RX_IDLE,
        SMON_RX_START,
        SMON_RX_DATA,
        SMON_RX_STOP
    } smon_rx_e;

endpackage : smon_pkg

//--- src/smon_byte_if.sv
// Byte carrier between the serial receiver, transmitter and command core.
// Assumes all three parties share one clock.
`timescale 1ns/10ps
interface smon_byte_if;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic [7:0] tx_data;
    logic       tx_start;
    logic       tx_busy;

    modport rx_side (output rx_data, output rx_valid);
    modport tx_side (input tx_data, input tx_start, output tx_busy);
    modport core    (input rx_data, input rx_valid, input tx_busy, output tx_data, output tx_start);
endinterface : smon_byte_if

//--- src/smon_uart_rx.sv
// Serial receiver: 8 data bits, no parity, one stop bit, idle high.
// Assumes the receive pin is asynchronous to clock_i.
`timescale 1ns/10ps
`include "smon_params.svh"
module smon_uart_rx
    import smon_pkg::*;
#(
    parameter int CLKS_PER_BIT = `SMON_CLKS_PER_BIT
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Serial pin
    input  wire logic rx_pin_i,
    // Received bytes
    smon_byte_if.rx_side bus
);
    localparam int CW = $clog2(CLKS_PER_BIT + 1);
    localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);
    localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2);

    logic          sync1_reg;
    logic          sync2_reg;
    logic          sync3_reg;
    logic          line_reg;
    smon_rx_e      state_reg;
    logic [CW-1:0] cnt_reg;
    logic [2:0]    idx_reg;
    logic [7:0]    shift_reg;
    logic          valid_reg;

    // Three-stage synchroniser; a level counts once stages two and three agree.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            sync3_reg <= 1'b1;
            line_reg  <= 1'b1;
        end else begin
            sync1_reg <= rx_pin_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                line_reg <= sync3_reg;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= SMON_RX_IDLE;
            cnt_reg   <= '0;
            idx_reg   <= 3'h0;
            shift_reg <= 8'h00;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            cnt_reg   <= cnt_reg + CW'(1);
            unique case (state_reg)
                SMON_RX_IDLE: begin
                    cnt_reg <= '0;
                    if (!line_reg) begin
                        state_reg <= SMON_RX_START;
                    end
                end
                SMON_RX_START: begin
                    if (cnt_reg == HALF) begin
                        cnt_reg   <= '0;
                        idx_reg   <= 3'h0;
                        state_reg <= line_reg ? SMON_RX_IDLE : SMON_RX_DATA;
                    end
                end
                SMON_RX_DATA: begin
                    if (cnt_reg == LAST) begin
                        cnt_reg   <= '0;
                        shift_reg <= {line_reg, shift_reg[7:1]};
                        idx_reg   <= idx_reg + 3'h1;
                        if (idx_reg == 3'h7) begin
                            state_reg <= SMON_RX_STOP;
                        end
                    end
                end
                SMON_RX_STOP: begin
                    if (cnt_reg == LAST) begin
                        valid_reg <= line_reg;
                        state_reg <= SMON_RX_IDLE;
                    end
                end
            endcase
        end
    end

    assign bus.rx_data  = shift_reg;
    assign bus.rx_valid = valid_reg;
endmodule : smon_uart_rx

//--- src/smon_uart_tx.sv
// Serial transmitter: 8 data bits, no parity, one stop bit, idle high.
// Assumes tx_start is only raised while tx_busy is low.
`timescale 1ns/10ps
`include "smon_params.svh"
module smon_uart_tx
#(
    parameter int CLKS_PER_BIT = `SMON_CLKS_PER_BIT
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Bytes to send
    smon_byte_if.tx_side bus,
    // Serial pin
    output logic      tx_pin_o
);
    localparam int CW = $clog2(CLKS_PER_BIT + 1);
    localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);

    logic [9:0]    frame_reg;
    logic [3:0]    left_reg;
    logic [CW-1:0] cnt_reg;
    logic          busy_reg;
    logic          pin_reg;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            frame_reg <= 10'h3FF;
            left_reg  <= 4'h0;
            cnt_reg   <= '0;
            busy_reg  <= 1'b0;
            pin_reg   <= 1'b1;
        end else if (!busy_reg) begin
            pin_reg <= 1'b1;
            if (bus.tx_start) begin
                frame_reg <= {1'b1, bus.tx_data, 1'b0};
                left_reg  <= 4'hA;
                cnt_reg   <= LAST;
                busy_reg  <= 1'b1;
            end
        end else if (cnt_reg == LAST) begin
            cnt_reg <= '0;
            if (left_reg == 4'h0) begin
                busy_reg <= 1'b0;
            end else begin
                pin_reg   <= frame_reg[0];
                frame_reg <= {1'b1, frame_reg[9:1]};
                left_reg  <= left_reg - 4'h1;
            end
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    assign bus.tx_busy = busy_reg;
    assign tx_pin_o    = pin_reg;
endmodule : smon_uart_tx

//--- src/smon_supply_regs.sv
// Supply monitor register block of a motor speed controller, reached over the serial command link.
// Assumes measurement, lock and trip inputs come from logic on clock_i; the serial pin is asynchronous.
//
// How it works
// - Low recovery level: write 0x47, read 0x07.
// - Low-supply status ends above low recovery level.
// - High status ends below high recovery level.
// - Supply above shutdown level shuts output down.
// - Shutdown on high supply sets overvoltage status.
// - Thresholds act only once written and locked.
// - Internal maximum may overwrite shutdown level.
// - Thresholds hold 12 bits, values 0 to 4095.
// - Read 0x0A: heatsink temperature clamped 10..80.
// - Read 0x0B: board temperature, never writable.
// - Read 0x10: measured supply, 12-bit read-only.
// - Read 0x11: speed input conversion, always reported.
// - Read 0x12: load current, 12-bit read-only.
// - Read 0x14: input signal period, 14 bits.
// - Threshold values are lost at restart.
// - Overvoltage is bit 1 of status word.
// - Locked values change only by serial write, or by the internal maximum for the shutdown level.
`timescale 1ns/10ps
`include "smon_params.svh"
module smon_supply_regs
    import smon_pkg::*;
#(
    parameter int CLKS_PER_BIT = `SMON_CLKS_PER_BIT
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Serial command link
    input  wire logic        uart_rx_i,
    output logic             uart_tx_o,
    // Measurements
    input  wire logic [11:0] heatsink_temp_i,
    input  wire logic [11:0] board_temp_i,
    input  wire logic [11:0] supply_level_i,
    input  wire logic [11:0] speed_conv_i,
    input  wire logic [11:0] load_current_i,
    input  wire logic [13:0] input_period_i,
    // Locks, trips and internal limit
    input  wire logic [2:0]  thresh_lock_i,
    input  wire logic        speed_lock_bit_i,
    input  wire logic        low_supply_trip_i,
    input  wire logic        max_limit_load_i,
    input  wire logic [11:0] max_limit_value_i,
    // Threshold state
    output logic [11:0]      low_recover_level_o,
    output logic [11:0]      high_recover_level_o,
    output logic [11:0]      shutdown_level_o,
    output logic [2:0]       thresh_active_o,
    // Supply status and drive
    output logic             overvoltage_flag_o,
    output logic             undervoltage_flag_o,
    output logic             output_shutdown_o,
    output logic [11:0]      speed_setting_o
);
    smon_byte_if link ();

    smon_cmd_e   state_reg;
    logic [7:0]  cmd_reg;
    logic [6:0]  hi_reg;
    logic [1:0]  wr_sel_reg;
    smon_word_t  rd_word_reg;
    smon_level_t level_reg [3];
    logic [2:0]  written_reg;
    logic [2:0]  active_reg;
    smon_level_t heat_reg;
    smon_level_t board_reg;
    smon_level_t supply_reg;
    smon_level_t speed_conv_reg;
    smon_level_t load_reg;
    smon_word_t  period_reg;
    smon_level_t speed_prev_reg;
    smon_level_t speed_setting_reg;
    logic        ov_reg;
    logic        uv_reg;
    logic        shutdown_reg;

    logic        ov_next;
    logic        uv_next;
    logic        wr_commit;
    logic [13:0] wr_value;
    logic        is_write;
    logic        is_read;
    logic [1:0]  cmd_sel;
    smon_word_t  rd_value;
    logic        data_ok;

    smon_uart_rx #(
        .CLKS_PER_BIT (CLKS_PER_BIT)
    ) u_rx (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .rx_pin_i (uart_rx_i),
        .bus      (link)
    );

    smon_uart_tx #(
        .CLKS_PER_BIT (CLKS_PER_BIT)
    ) u_tx (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .bus      (link),
        .tx_pin_o (uart_tx_o)
    );

    // Command decode of a received byte.
    always_comb begin
        is_write = 1'b0;
        is_read  = 1'b0;
        cmd_sel  = 2'(`SMON_IDX_LOW_REC);
        unique case (link.rx_data)
            `SMON_CMD_WR_LOW_REC: begin
                is_write = 1'b1;
                cmd_sel  = 2'(`SMON_IDX_LOW_REC);
            end
            `SMON_CMD_WR_HIGH_REC: begin
                is_write = 1'b1;
                cmd_sel  = 2'(`SMON_IDX_HIGH_REC);
            end
            `SMON_CMD_WR_SHUTDOWN: begin
                is_write = 1'b1;
                cmd_sel  = 2'(`SMON_IDX_SHUTDOWN);
            end
            `SMON_CMD_RD_LOW_REC,
            `SMON_CMD_RD_HIGH_REC,
            `SMON_CMD_RD_SHUTDOWN,
            `SMON_CMD_RD_HEATSINK,
            `SMON_CMD_RD_BOARD,
            `SMON_CMD_RD_SUPPLY,
            `SMON_CMD_RD_SPEED,
            `SMON_CMD_RD_LOAD,
            `SMON_CMD_RD_PERIOD,
            `SMON_CMD_RD_STATUS: begin
                is_read = 1'b1;
            end
            default: begin
                is_read = 1'b0;
            end
        endcase
    end

    // Read data selection; measurement commands have no write code.
    always_comb begin
        rd_value = 14'h0000;
        unique case (link.rx_data)
            `SMON_CMD_RD_LOW_REC:  rd_value = {2'b00, level_reg[`SMON_IDX_LOW_REC]};
            `SMON_CMD_RD_HIGH_REC: rd_value = {2'b00, level_reg[`SMON_IDX_HIGH_REC]};
            `SMON_CMD_RD_SHUTDOWN: rd_value = {2'b00, level_reg[`SMON_IDX_SHUTDOWN]};
            `SMON_CMD_RD_HEATSINK: rd_value = {2'b00, heat_reg};
            `SMON_CMD_RD_BOARD:    rd_value = {2'b00, board_reg};
            `SMON_CMD_RD_SUPPLY:   rd_value = {2'b00, supply_reg};
            `SMON_CMD_RD_SPEED:    rd_value = {2'b00, speed_conv_reg};
            `SMON_CMD_RD_LOAD:     rd_value = {2'b00, load_reg};
            `SMON_CMD_RD_PERIOD:   rd_value = period_reg;
            `SMON_CMD_RD_STATUS: begin
                rd_value[`SMON_STATUS_OV_BIT] = ov_reg;
                rd_value[`SMON_STATUS_UV_BIT] = uv_reg;
            end
            default: rd_value = 14'h0000;
        endcase
    end

    // A data byte with bit 7 set is not data and aborts the command.
    assign data_ok   = !link.rx_data[`SMON_DATA_FLAG_BIT];
    assign wr_value  = {hi_reg, link.rx_data[6:0]};
    assign wr_commit = (state_reg == SMON_WR_LO) && link.rx_valid && data_ok
                       && (wr_value <= `SMON_LEVEL_MAX);

    // Answer bytes go out high part first, each with bit 7 clear.
    assign link.tx_start = ((state_reg == SMON_RD_HI) || (state_reg == SMON_RD_LO)) && !link.tx_busy;
    assign link.tx_data  = (state_reg == SMON_RD_HI) ? {1'b0, rd_word_reg[13:`SMON_HI_LSB]}
                                                     : {1'b0, rd_word_reg[`SMON_HI_LSB-1:0]};

    // Command sequencer.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg   <= SMON_IDLE;
            cmd_reg     <= 8'h00;
            hi_reg      <= 7'h00;
            wr_sel_reg  <= 2'h0;
            rd_word_reg <= 14'h0000;
        end else begin
            unique case (state_reg)
                SMON_IDLE: begin
                    if (link.rx_valid) begin
                        cmd_reg <= link.rx_data;
                        if (is_write) begin
                            wr_sel_reg <= cmd_sel;
                            state_reg  <= SMON_WR_HI;
                        end else if (is_read) begin
                            rd_word_reg <= rd_value;
                            state_reg   <= SMON_RD_HI;
                        end
                    end
                end
                SMON_WR_HI: begin
                    if (link.rx_valid) begin
                        hi_reg    <= link.rx_data[6:0];
                        state_reg <= data_ok ? SMON_WR_LO : SMON_IDLE;
                    end
                end
                SMON_WR_LO: begin
                    if (link.rx_valid) begin
                        state_reg <= SMON_IDLE;
                    end
                end
                SMON_RD_HI: begin
                    if (!link.tx_busy) begin
                        state_reg <= SMON_RD_LO;
                    end
                end
                SMON_RD_LO: begin
                    if (!link.tx_busy) begin
                        state_reg <= SMON_IDLE;
                    end
                end
            endcase
        end
    end

    // Threshold storage; cleared at every restart, the save path lives outside.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                level_reg[i] <= `SMON_LEVEL_RESET;
            end
            written_reg <= 3'h0;
        end else begin
            if (max_limit_load_i) begin
                level_reg[`SMON_IDX_SHUTDOWN] <= max_limit_value_i;
            end
            for (int i = 0; i < 3; i++) begin
                if (wr_commit && (wr_sel_reg == 2'(i))) begin
                    level_reg[i]   <= wr_value[11:0];
                    written_reg[i] <= 1'b1;
                end
            end
        end
    end

    // A threshold works only after both a write and its lock.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            active_reg <= 3'h0;
        end else begin
            active_reg <= written_reg & thresh_lock_i;
        end
    end

    // Present measurements; heatsink reading is held to its reporting range.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            heat_reg       <= `SMON_HEAT_MIN;
            board_reg      <= 12'h000;
            supply_reg     <= 12'h000;
            speed_conv_reg <= 12'h000;
            load_reg       <= 12'h000;
            period_reg     <= 14'h0000;
        end else begin
            if (heatsink_temp_i < `SMON_HEAT_MIN) begin
                heat_reg <= `SMON_HEAT_MIN;
            end else if (heatsink_temp_i > `SMON_HEAT_MAX) begin
                heat_reg <= `SMON_HEAT_MAX;
            end else begin
                heat_reg <= heatsink_temp_i;
            end
            board_reg      <= board_temp_i;
            supply_reg     <= supply_level_i;
            speed_conv_reg <= speed_conv_i;
            load_reg       <= load_current_i;
            period_reg     <= input_period_i;
        end
    end

    // Speed setting follows the speed input only while it is unlocked.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            speed_prev_reg    <= 12'h000;
            speed_setting_reg <= 12'h000;
        end else begin
            speed_prev_reg <= speed_conv_reg;
            if (!speed_lock_bit_i && (speed_conv_reg != speed_prev_reg)) begin
                speed_setting_reg <= speed_conv_reg;
            end
        end
    end

    // Supply status; a setting condition wins over a clearing one.
    always_comb begin
        ov_next = ov_reg;
        if (active_reg[`SMON_IDX_SHUTDOWN] && (supply_reg > level_reg[`SMON_IDX_SHUTDOWN])) begin
            ov_next = 1'b1;
        end else if (ov_reg) begin
            if (active_reg[`SMON_IDX_HIGH_REC]) begin
                ov_next = !(supply_reg < level_reg[`SMON_IDX_HIGH_REC]);
            end else begin
                ov_next = !(supply_reg <= level_reg[`SMON_IDX_SHUTDOWN]);
            end
        end
        uv_next = uv_reg;
        if (low_supply_trip_i) begin
            uv_next = 1'b1;
        end else if (uv_reg) begin
            if (active_reg[`SMON_IDX_LOW_REC]) begin
                uv_next = !(supply_reg > level_reg[`SMON_IDX_LOW_REC]);
            end else begin
                uv_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ov_reg       <= 1'b0;
            uv_reg       <= 1'b0;
            shutdown_reg <= 1'b0;
        end else begin
            ov_reg       <= ov_next;
            uv_reg       <= uv_next;
            shutdown_reg <= ov_next | uv_next;
        end
    end

    assign low_recover_level_o  = level_reg[`SMON_IDX_LOW_REC];
    assign high_recover_level_o = level_reg[`SMON_IDX_HIGH_REC];
    assign shutdown_level_o     = level_reg[`SMON_IDX_SHUTDOWN];
    assign thresh_active_o      = active_reg;
    assign overvoltage_flag_o   = ov_reg;
    assign undervoltage_flag_o  = uv_reg;
    assign output_shutdown_o    = shutdown_reg;
    assign speed_setting_o      = speed_setting_reg;
endmodule : smon_supply_regs

//--- test/smon_host.sv
// Host model of the serial command link: sends and receives 8N1 bytes.
// Assumes the bench calls its tasks at a rising clock edge.
`timescale 1ns/10ps
module smon_host #(
    parameter int CPB = 8
) (
    // Serial lines
    input  wire logic clock_i,
    output logic      line_o,
    input  wire logic line_i
);
    initial line_o = 1'b1;

    // Frame is start, eight data bits low first, stop; line idles high.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge clock_i);
        for (int i = 0; i < 10; i++) begin
            #1 line_o = f[i];
            repeat (CPB) @(posedge clock_i);
        end
    endtask : send

    // Gives all ones when no start bit comes within the bound.
    task automatic recv(output logic [7:0] b);
        int n;
        b = 8'hFF;
        for (n = 0; n < 400 && line_i !== 1'b0; n++) @(posedge clock_i);
        if (n < 400) begin
            repeat (CPB / 2) @(posedge clock_i);
            for (int i = 0; i < 8; i++) begin
                repeat (CPB) @(posedge clock_i);
                b[i] = line_i;
            end
            repeat (CPB) @(posedge clock_i);
        end
    endtask : recv
endmodule : smon_host

//--- test/smon_checker_assertions.sv
// Checker of the supply monitor register block.
// Assumes it is bound to smon_supply_regs and sees only its ports.
`timescale 1ns/10ps
module smon_checker (
    // Watched ports
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        uart_tx_o,
    input wire logic [11:0] supply_level_i,
    input wire logic [2:0]  thresh_lock_i,
    input wire logic        speed_lock_bit_i,
    input wire logic        low_supply_trip_i,
    input wire logic        max_limit_load_i,
    input wire logic [11:0] max_limit_value_i,
    input wire logic [11:0] low_recover_level_o,
    input wire logic [11:0] high_recover_level_o,
    input wire logic [11:0] shutdown_level_o,
    input wire logic [2:0]  thresh_active_o,
    input wire logic        overvoltage_flag_o,
    input wire logic        undervoltage_flag_o,
    input wire logic        output_shutdown_o,
    input wire logic [11:0] speed_setting_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_shutdown_drive:
        assert property (output_shutdown_o == (overvoltage_flag_o | undervoltage_flag_o)) else $error("shutdown mismatch");
    a_reset_state:
        assert property ($rose(rst_n_i) |-> uart_tx_o && thresh_active_o == 3'h0 && shutdown_level_o == 12'h000)
        else $error("bad state after reset");
    a_active_lock:
        assert property ((thresh_active_o & ~$past(thresh_lock_i)) == 3'h0) else $error("active without lock");
    a_ov_cause:
        assert property ($rose(overvoltage_flag_o) |-> thresh_active_o[2] && $past(supply_level_i, 2) > shutdown_level_o)
        else $error("overvoltage without cause");
    a_ov_release:
        assert property ($fell(overvoltage_flag_o) && thresh_active_o[1] |-> $past(supply_level_i, 2) < high_recover_level_o)
        else $error("overvoltage cleared early");
    a_uv_release:
        assert property ($fell(undervoltage_flag_o) && thresh_active_o[0] |-> $past(supply_level_i, 2) > low_recover_level_o)
        else $error("undervoltage cleared early");
    a_uv_entry:
        assert property (low_supply_trip_i |-> ##[1:2] undervoltage_flag_o) else $error("trip not seen");
    a_max_load:
        assert property (max_limit_load_i |=> shutdown_level_o == $past(max_limit_value_i)) else $error("limit not loaded");
    a_speed_frozen:
        assert property (speed_lock_bit_i && $past(speed_lock_bit_i) && $past(speed_lock_bit_i, 2) |-> $stable(speed_setting_o))
        else $error("locked speed changed");
endmodule : smon_checker

bind smon_supply_regs smon_checker i_chk (.clock_i, .rst_n_i, .uart_tx_o, .supply_level_i, .thresh_lock_i,
    .speed_lock_bit_i, .low_supply_trip_i, .max_limit_load_i, .max_limit_value_i, .low_recover_level_o,
    .high_recover_level_o, .shutdown_level_o, .thresh_active_o, .overvoltage_flag_o, .undervoltage_flag_o,
    .output_shutdown_o, .speed_setting_o);

//--- test/tb.sv
// Self-checking bench of the supply monitor register block with a serial host model.
// Assumes the design runs with eight clocks per serial bit.
`timescale 1ns/10ps
module tb;
    logic clock_i, rst_n_i, rx, tx, speed_lock_bit, trip, mload, ov, uv, shut;
    logic [11:0] heat, board, sup, conv, load, mval, low, high, sdl, spo;
    logic [13:0] per, v;
    logic [2:0] lock, act;
    int n_errors, checked, cycles, lv[3], ex[6];
    logic [7:0] cd[6] = '{8'h0A, 8'h0B, 8'h10, 8'h11, 8'h12, 8'h14};

    smon_host #(.CPB(8)) i_host (.clock_i(clock_i), .line_o(rx), .line_i(tx));
    smon_supply_regs #(.CLKS_PER_BIT(8)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .uart_rx_i(rx), .uart_tx_o(tx),
        .heatsink_temp_i(heat), .board_temp_i(board), .supply_level_i(sup), .speed_conv_i(conv),
        .load_current_i(load), .input_period_i(per), .thresh_lock_i(lock), .speed_lock_bit_i(speed_lock_bit),
        .low_supply_trip_i(trip), .max_limit_load_i(mload), .max_limit_value_i(mval), .low_recover_level_o(low),
        .high_recover_level_o(high), .shutdown_level_o(sdl), .thresh_active_o(act), .overvoltage_flag_o(ov),
        .undervoltage_flag_o(uv), .output_shutdown_o(shut), .speed_setting_o(spo));

    task automatic chk(input string s, input logic [13:0] g, input logic [13:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", s, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] c, input logic [13:0] d);
        i_host.send(c);
        i_host.send({1'b0, d[13:7]});
        i_host.send({1'b0, d[6:0]});
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [13:0] d);
        logic [7:0] h, l;
        i_host.send(c);
        i_host.recv(h);
        i_host.recv(l);
        chk("flag bits", 14'({h[7], l[7]}), 14'h0000);
        d = {h[6:0], l[6:0]};
        #1;
    endtask : rd
    task end_sim;
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        {rst_n_i, heat, board, sup, conv, load, per, lock, speed_lock_bit, trip, mload, mval} = '0;
        void'($urandom(32'hceb27dae));
        step(16);
        rst_n_i = 1'b1;
        step(4);
        for (int k = 0; k < 3; k++) begin
            lv[k] = 1000 * (k + 1) + $urandom % 1000;
            wr(8'h47 + 8'(k), 14'(lv[k]));
        end
        wr(8'h47, 14'h1000);
        for (int k = 0; k < 3; k++) begin
            rd(8'h07 + 8'(k), v);
            chk("threshold", v, 14'(lv[k]));
        end
        chk("levels", 14'(high), 14'(lv[1]));
        chk("inactive", 14'(act), 14'h0000);
        lock = 3'h7;
        step(3);
        chk("active", 14'(act), 14'h0007);
        {heat, board, sup, conv, load, per} = 74'({$urandom, $urandom, $urandom});
        heat = 12'($urandom % 100);
        sup = 12'(lv[2]);
        ex = '{heat < 10 ? 10 : heat > 80 ? 80 : heat, board, sup, conv, load, per};
        for (int k = 0; k < 6; k++) begin
            rd(cd[k], v);
            chk("measurement", v, 14'(ex[k]));
        end
        chk("no trip at level", 14'(ov), 14'h0000);
        sup = 12'(lv[2] + 1);
        step(5);
        chk("shutdown", 14'({ov, shut}), 14'h0003);
        rd(8'h30, v);
        chk("status", v, 14'h0002);
        sup = 12'(lv[1]);
        step(5);
        chk("ov held", 14'(ov), 14'h0001);
        sup = 12'(lv[1] - 1);
        step(5);
        chk("ov cleared", 14'(ov), 14'h0000);
        trip = 1'b1;
        sup = 12'(lv[0]);
        step(3);
        trip = 1'b0;
        step(5);
        chk("uv held", 14'({uv, shut}), 14'h0003);
        sup = 12'(lv[0] + 1);
        step(5);
        chk("uv cleared", 14'(uv), 14'h0000);
        mval = 12'($urandom);
        mload = 1'b1;
        step(1);
        mload = 1'b0;
        rd(8'h09, v);
        chk("internal limit", v, 14'(mval));
        step(4);
        v = 14'(conv);
        speed_lock_bit = 1'b1;
        step(3);
        conv = ~conv;
        step(5);
        chk("locked speed", 14'(spo), v);
        rd(8'h11, v);
        chk("speed input", v, 14'(conv));
        rst_n_i = 1'b0;
        step(4);
        rst_n_i = 1'b1;
        step(4);
        chk("cleared", 14'({low, high}), 14'h0000);
        chk("locked but unwritten", 14'(act), 14'h0000);
        end_sim();
    end
endmodule : tb
